// File: pir_defs.vh
// Purpose: Constants for the PCI interrupt rerouter
// Assumes: Included by every rerouter design file
// Notes:   Definitions only
`ifndef PIR_DEFS_VH
`define PIR_DEFS_VH

// ********************************************************
// Register map (index taken from reg_addr_bit0)
// ********************************************************
`define PIR_IDX_ROUTE_LOW    1'b0
`define PIR_IDX_ROUTE_HIGH   1'b1
`define PIR_ROUTE_RESET      8'h00

// ********************************************************
// Field layout: low reg = lines A,B; high reg = lines C,D
// ********************************************************
`define PIR_NIB_LO_MSB       3
`define PIR_NIB_LO_LSB       0
`define PIR_NIB_HI_MSB       7
`define PIR_NIB_HI_LSB       4

// ********************************************************
// Routing codes
// ********************************************************
`define PIR_CODE_PASS        4'h0
`define PIR_CODE_IRQ3        4'h1
`define PIR_CODE_IRQ4        4'h2
`define PIR_CODE_IRQ5        4'h3
`define PIR_CODE_IRQ7        4'h4
`define PIR_CODE_IRQ10       4'h5
`define PIR_CODE_IRQ11       4'h6
`define PIR_CODE_IRQ12       4'h7
`define PIR_CODE_IRQ15       4'h8

// ********************************************************
// ISA IRQ output bit positions
// ********************************************************
`define PIR_NUM_IRQ          8
`define PIR_NUM_LINE         4
`define PIR_BIT_IRQ3         0
`define PIR_BIT_IRQ4         1
`define PIR_BIT_IRQ5         2
`define PIR_BIT_IRQ7         3
`define PIR_BIT_IRQ10        4
`define PIR_BIT_IRQ11        5
`define PIR_BIT_IRQ12        6
`define PIR_BIT_IRQ15        7

`endif

// File: pir_nmi_smi.v
// Purpose: Error forwarding onto NMI and SMI
// Assumes: All inputs synchronous to sys_clk
// Notes:   Latched SMI cleared by smiClear, latched NMI by nmiClear
`timescale 1ns/1ps
`include "pir_defs.vh"

module pir_nmi_smi (
  // Clock and reset
  input  wire sys_clk,
  input  wire rst_b,
  // Controls
  input  wire smiEnable,
  input  wire nmiEnable,
  input  wire smiClear,
  input  wire nmiClear,
  // Error and request sources
  input  wire errReq,
  input  wire critErr,
  input  wire bridgeNmiReq,
  input  wire fpNmiN,
  // Processor signalling
  output reg  cpuNmi,
  output reg  mgmt_interrupt_n
);

  reg  fpPrev_r;
  reg  smiPend_r;
  reg  nmiPend_r;
  wire fpPress;
  wire smiSet;
  wire nmiSet;

  assign fpPress = fpPrev_r & ~fpNmiN;
  // Errors go to SMI when enabled, else straight to NMI
  assign smiSet  = (errReq | critErr) & smiEnable; // [RULE_11] [RULE_13]
  // Critical errors reach NMI even when intercepted by SMI
  assign nmiSet  = (errReq & ~smiEnable) // [RULE_11]
                 | critErr               // [RULE_12]
                 | (bridgeNmiReq & nmiEnable)
                 | fpPress;

  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      fpPrev_r         <= 1'b1;
      smiPend_r        <= 1'b0;
      nmiPend_r        <= 1'b0;
      cpuNmi           <= 1'b0;
      mgmt_interrupt_n <= 1'b1;
    end else begin
      fpPrev_r  <= fpNmiN;
      // Set wins over clear
      smiPend_r <= smiSet | (smiPend_r & ~smiClear);
      nmiPend_r <= nmiSet | (nmiPend_r & ~nmiClear);
      cpuNmi    <= nmiPend_r;
      mgmt_interrupt_n <= ~smiPend_r; // [RULE_13]
    end
  end

endmodule

// File: pir_rerouter.v
// Purpose: PCI interrupt to ISA IRQ rerouter with NMI/SMI forwarding
// Assumes: All pins synchronous to sys_clk; chip select decoded outside
// Notes:   Two 8-bit routing registers, aliased over a 4-byte window
//
// Functional notes
// [RULE_01] Each line passes to APIC or ISA IRQ
// [RULE_02] Each line routed independently of others
// [RULE_03] Two 8-bit registers, one nibble per line
// [RULE_04] Two registers alias across four-byte window
// [RULE_05] Bridge decodes address, drives chip select
// [RULE_06] Timer INT2, keyboard INT1, processor INT0
// [RULE_07] Legacy IRQs map to same APIC input
// [RULE_08] Pass-through lines A-D reach inputs 16-19
// [RULE_09] Accept slot INTA, cascaded B-D, SCSI, LAN; code takes no SCSI input
// [RULE_10] Only rerouter feeds PCI interrupts to APIC
// [RULE_11] SMI enabled intercepts errors, else NMI
// [RULE_12] Critical errors still raise NMI after SMI
// [RULE_13] Non-ISA errors signalled via NMI and SMI
// [RULE_14] Targets IRQ3,4,5,7,10,11,12,15
// [RULE_15] Access via select, two address bits, strobes
// [RULE_16] Resets select pass-through, IRQs undriven
// [RULE_17] Distinct codes; undefined codes pass through
`timescale 1ns/1ps
`include "pir_defs.vh"

module pir_rerouter (
  // Clock and reset
  input  wire       sys_clk,
  input  wire       rst_b,
  input  wire       isaRstN,
  input  wire       pciRstN,
  // ISA register access
  input  wire       rerouter_chip_select_n,
  input  wire       reg_addr_bit0,
  input  wire       reg_addr_bit1,
  input  wire       ioRdN,
  input  wire       ioWrN,
  input  wire [7:0] dataIn,
  output reg  [7:0] dataOut,
  output reg        dataOe,
  // PCI interrupt sources
  input  wire       slot1_int_in_n,
  input  wire       slot2IntInN,
  input  wire       slot3IntInN,
  input  wire       slot4IntInN,
  input  wire       cascIntBN,
  input  wire       cascIntCN,
  input  wire       cascIntDN,
  input  wire       lan_int_in_n,
  // APIC PCI inputs 16-19, active low
  output reg  [3:0] apicPciIntN,
  // ISA IRQ outputs: 3,4,5,7,10,11,12,15
  output reg  [7:0] isaIrqOut,
  output reg  [7:0] isaIrqOe,
  // Error forwarding
  input  wire       smiEnable,
  input  wire       nmiEnable,
  input  wire       smiClear,
  input  wire       nmiClear,
  input  wire       errReq,
  input  wire       critErr,
  input  wire       bridgeNmiReq,
  input  wire       fpNmiN,
  output wire       cpuNmi,
  output wire       mgmt_interrupt_n
);

  // ********************************************************
  // Code decode
  // ********************************************************
  // Returns one-hot ISA IRQ target, zero means pass-through
  function [7:0] decodeTarget;
    input [3:0] code;
    begin
      decodeTarget = 8'h00;
      case (code) // [RULE_17]
        `PIR_CODE_IRQ3:  decodeTarget[`PIR_BIT_IRQ3]  = 1'b1;
        `PIR_CODE_IRQ4:  decodeTarget[`PIR_BIT_IRQ4]  = 1'b1;
        `PIR_CODE_IRQ5:  decodeTarget[`PIR_BIT_IRQ5]  = 1'b1;
        `PIR_CODE_IRQ7:  decodeTarget[`PIR_BIT_IRQ7]  = 1'b1;
        `PIR_CODE_IRQ10: decodeTarget[`PIR_BIT_IRQ10] = 1'b1;
        `PIR_CODE_IRQ11: decodeTarget[`PIR_BIT_IRQ11] = 1'b1;
        `PIR_CODE_IRQ12: decodeTarget[`PIR_BIT_IRQ12] = 1'b1;
        `PIR_CODE_IRQ15: decodeTarget[`PIR_BIT_IRQ15] = 1'b1;
        default:         decodeTarget = 8'h00;
      endcase
    end
  endfunction

  // True when the index bit picks the low routing register
  function isLowReg;
    input idx;
    begin
      isLowReg = (idx == `PIR_IDX_ROUTE_LOW);
    end
  endfunction

  // Routing field of one PCI line: A,B in low reg, C,D in high reg
  function [3:0] lineCode;
    input [7:0] lo;
    input [7:0] hi;
    input [1:0] lineIdx;
    begin
      case (lineIdx)
        2'd0:    lineCode = lo[`PIR_NIB_LO_MSB:`PIR_NIB_LO_LSB];
        2'd1:    lineCode = lo[`PIR_NIB_HI_MSB:`PIR_NIB_HI_LSB];
        2'd2:    lineCode = hi[`PIR_NIB_LO_MSB:`PIR_NIB_LO_LSB];
        default: lineCode = hi[`PIR_NIB_HI_MSB:`PIR_NIB_HI_LSB];
      endcase
    end
  endfunction

  // ********************************************************
  // Register access
  // ********************************************************
  reg  [7:0] routeLow_r;
  reg  [7:0] routeHigh_r;
  reg        ioWrPrev_r;
  wire       selected;
  wire       wrStart;
  wire       routeClear;
  wire       unusedAddr;

  assign selected   = ~rerouter_chip_select_n;             // [RULE_05]
  assign wrStart    = selected & ioWrPrev_r & ~ioWrN;      // [RULE_15]
  assign routeClear = ~isaRstN | ~pciRstN;                 // [RULE_16]
  // Address bit 1 does not take part in decode
  assign unusedAddr = reg_addr_bit1;                       // [RULE_04]

  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ioWrPrev_r  <= 1'b1;
      routeLow_r  <= `PIR_ROUTE_RESET;
      routeHigh_r <= `PIR_ROUTE_RESET;
    end else begin
      ioWrPrev_r <= ioWrN;
      if (routeClear) begin
        routeLow_r  <= `PIR_ROUTE_RESET; // [RULE_16]
        routeHigh_r <= `PIR_ROUTE_RESET;
      end else if (wrStart) begin
        if (isLowReg(reg_addr_bit0)) begin // [RULE_03] [RULE_04]
          routeLow_r <= dataIn;
        end else begin
          routeHigh_r <= dataIn;
        end
      end
    end
  end

  // Read data and bus drive follow the strobe one clock later
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      dataOut <= 8'h00;
      dataOe  <= 1'b0;
    end else begin
      dataOe  <= selected & ~ioRdN & ~(unusedAddr & 1'b0); // [RULE_15]
      if (isLowReg(reg_addr_bit0)) begin
        dataOut <= routeLow_r;
      end else begin
        dataOut <= routeHigh_r;
      end
    end
  end

  // ********************************************************
  // Interrupt routing
  // ********************************************************
  reg  [3:0] lineAct;
  reg  [3:0] lineRedir;
  reg  [7:0] irqNxt;
  reg  [7:0] oeNxt;
  reg  [7:0] tgt;
  reg  [3:0] code;
  integer    i;

  always @* begin
    // Line A gathers every slot INTA and the LAN controller
    lineAct[0] = ~slot1_int_in_n | ~slot2IntInN | ~slot3IntInN
               | ~slot4IntInN | ~lan_int_in_n;              // [RULE_09]
    lineAct[1] = ~cascIntBN;
    lineAct[2] = ~cascIntCN;
    lineAct[3] = ~cascIntDN;
    irqNxt     = 8'h00;
    oeNxt      = 8'h00;
    lineRedir  = 4'h0;
    tgt        = 8'h00;
    code       = 4'h0;
    for (i = 0; i < `PIR_NUM_LINE; i = i + 1) begin
      code         = lineCode(routeLow_r, routeHigh_r, i[1:0]);  // [RULE_03]
      tgt          = decodeTarget(code);                    // [RULE_02] [RULE_14]
      lineRedir[i] = |tgt;                                  // [RULE_01]
      oeNxt        = oeNxt | tgt;
      irqNxt       = irqNxt | (tgt & {8{lineAct[i]}});      // [RULE_09]
    end
  end

  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      apicPciIntN <= 4'hf;
      isaIrqOut   <= 8'h00;
      isaIrqOe    <= 8'h00;
    end else begin
      // Redirected lines are held idle at the APIC
      apicPciIntN <= ~(lineAct & ~lineRedir);               // [RULE_08] [RULE_10]
      isaIrqOut   <= irqNxt;                                // [RULE_01]
      isaIrqOe    <= oeNxt;                                 // [RULE_16]
    end
  end

  // ********************************************************
  // Error forwarding
  // ********************************************************
  pir_nmi_smi uNmiSmi (
    .sys_clk          (sys_clk),
    .rst_b            (rst_b),
    .smiEnable        (smiEnable),
    .nmiEnable        (nmiEnable),
    .smiClear         (smiClear),
    .nmiClear         (nmiClear),
    .errReq           (errReq),
    .critErr          (critErr),
    .bridgeNmiReq     (bridgeNmiReq),
    .fpNmiN           (fpNmiN),
    .cpuNmi           (cpuNmi),
    .mgmt_interrupt_n (mgmt_interrupt_n)
  );

endmodule

// File: pir_rerouter_chk.sv
// Purpose: Port-level checks for pir_rerouter
// Assumes: Bound to the top module, one clock domain
// Notes:   Output latencies as agreed at hand-over
`timescale 1ns/1ps
module pir_rerouter_chk (
  // Clock and resets
  input wire       sys_clk,
  input wire       rst_b,
  input wire       isaRstN,
  input wire       pciRstN,
  // Register access
  input wire       rerouter_chip_select_n,
  input wire       ioRdN,
  input wire       ioWrN,
  input wire       dataOe,
  // Routing
  input wire       cascIntBN,
  input wire       cascIntCN,
  input wire       cascIntDN,
  input wire [3:0] apicPciIntN,
  input wire [7:0] isaIrqOe,
  // Error forwarding
  input wire       smiEnable,
  input wire       nmiEnable,
  input wire       errReq,
  input wire       critErr,
  input wire       bridgeNmiReq,
  input wire       cpuNmi,
  input wire       mgmt_interrupt_n
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  route_clear_a: assert property (!(isaRstN && pciRstN) |-> ##2 isaIrqOe == 8'h00)
    else $error("routing not cleared");
  route_hold_a: assert property (ioWrN && $past(ioWrN) && isaRstN && pciRstN
    |-> ##2 $stable(isaIrqOe)) else $error("routing changed without write");
  // First edge after reset still shows reset values, not the inputs
  pass_thru_a: assert property ($past(rst_b) && isaIrqOe == 8'h00 |->
    apicPciIntN[3:1] == {$past(cascIntDN), $past(cascIntCN), $past(cascIntBN)})
    else $error("apic not passed");
  read_drive_a: assert property (!rerouter_chip_select_n && !ioRdN |=> dataOe)
    else $error("read not driven");
  read_idle_a: assert property (rerouter_chip_select_n |=> !dataOe)
    else $error("bus driven when idle");
  smi_err_a: assert property ((errReq || critErr) && smiEnable
    |-> ##[1:3] !mgmt_interrupt_n) else $error("smi missing");
  nmi_err_a: assert property (errReq && !smiEnable |-> ##[1:3] cpuNmi)
    else $error("nmi missing");
  nmi_crit_a: assert property (critErr |-> ##[1:3] cpuNmi)
    else $error("critical nmi missing");
  nmi_bridge_a: assert property (bridgeNmiReq && nmiEnable |-> ##[1:3] cpuNmi)
    else $error("bridge nmi missing");
endmodule

// File: pir_isa_host.sv
// Purpose: South bridge ISA I/O cycle model
// Assumes: Chip select already decoded for the window
// Notes:   Idle data bus shows the inverse of the last byte
`timescale 1ns/1ps
module pir_isa_host (
  // Clock
  input  wire      sys_clk,
  // ISA I/O cycle
  output reg       rerouter_chip_select_n,
  output reg       reg_addr_bit0,
  output reg       reg_addr_bit1,
  output reg       ioRdN,
  output reg       ioWrN,
  output reg [7:0] dataIn
);
  initial begin
    {rerouter_chip_select_n, ioRdN, ioWrN} = 3'h7;
    {reg_addr_bit1, reg_addr_bit0, dataIn} = 10'h000;
  end
  task wr(input [1:0] a, input [7:0] d);
    begin
      {reg_addr_bit1, reg_addr_bit0, dataIn} = {a, d};
      {rerouter_chip_select_n, ioWrN} = 2'b00;
      @(posedge sys_clk) #1;
      {rerouter_chip_select_n, ioWrN} = 2'b11;
      dataIn = ~d;
      @(posedge sys_clk) #1;
    end
  endtask
  task rd(input [1:0] a);
    begin
      {reg_addr_bit1, reg_addr_bit0} = a;
      {rerouter_chip_select_n, ioRdN} = 2'b00;
      repeat (2) @(posedge sys_clk) #1;
      {rerouter_chip_select_n, ioRdN} = 2'b11;
      @(posedge sys_clk) #1;
    end
  endtask
endmodule

// File: pir_rerouter_tb.sv
// Purpose: Self-checking bench for pir_rerouter
// Assumes: Partner model runs the ISA I/O cycles
// Notes:   Read data compared against a queue of expectations
`timescale 1ns/1ps
module pir_rerouter_tb;
  reg        sys_clk = 1'b0, rst_b = 1'b0, isaRstN = 1'b1, pciRstN = 1'b1;
  reg        cascIntBN = 1'b1, cascIntCN = 1'b1, cascIntDN = 1'b1, fpNmiN = 1'b1;
  reg        smiEnable = 1'b0, nmiEnable = 1'b0, smiClear = 1'b0, nmiClear = 1'b0;
  reg        errReq = 1'b0, critErr = 1'b0, bridgeNmiReq = 1'b0, oeSeen = 1'b0;
  reg  [4:0] srcN = 5'h1f;
  reg  [6:0] e;
  reg  [7:0] expIrq;
  reg  [7:0] expQ[$];
  reg [31:0] seed = 32'd20;
  wire       rerouter_chip_select_n, reg_addr_bit0, reg_addr_bit1, ioRdN, ioWrN;
  wire       dataOe, cpuNmi, mgmt_interrupt_n;
  wire [7:0] dataIn, dataOut, isaIrqOut, isaIrqOe;
  wire [3:0] apicPciIntN;
  wire       slot1_int_in_n = srcN[0], slot2IntInN = srcN[1], slot3IntInN = srcN[2];
  wire       slot4IntInN = srcN[3], lan_int_in_n = srcN[4];
  integer    mismatches = 0, num_checks = 0, i, k;
  always #5 sys_clk = ~sys_clk;
  pir_rerouter u_pir_rerouter (.*);
  pir_isa_host u_pir_isa_host (.*);
  function [31:0] xs(input [31:0] s);
    reg [31:0] t;
    begin
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      xs = t ^ (t << 5);
    end
  endfunction
  // Expected one-hot ISA IRQ for a routing code: 1-8 pick bits 0-7, others pass through
  function [7:0] irqOf(input [3:0] c);
    irqOf = (c >= 4'h1 && c <= 4'h8) ? 8'h01 << (c - 4'h1) : 8'h00;
  endfunction
  task chk(input [7:0] seen, input [7:0] exp, input [8*6:1] what);
    begin
      num_checks = num_checks + 1;
      if (seen !== exp) begin
        mismatches = mismatches + 1;
        $display("unexpected %0s: expected %h seen %h", what, exp, seen);
      end
    end
  endtask
  task rd(input [1:0] a, input [7:0] ex);
    begin
      expQ.push_back(ex);
      u_pir_isa_host.rd(a);
    end
  endtask
  task test_done;
    begin
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0)
        $display("== PASSED ==");
      else
        $display("== FAILED ==");
      $finish;
    end
  endtask
  always @(negedge sys_clk) begin
    if (dataOe === 1'b1 && !oeSeen)
      chk(dataOut, expQ.pop_front(), "rdata");
    oeSeen = (dataOe === 1'b1);
  end
  initial begin
    #20000;
    mismatches = mismatches + 1;
    test_done;
  end
  initial begin
    repeat (4) @(posedge sys_clk) #1;
    rst_b = 1'b1;
    @(posedge sys_clk) #1;
    rd(2'b00, 8'h00);
    rd(2'b01, 8'h00);
    chk(isaIrqOe, 8'h00, "irqOe");
    chk({4'h0, apicPciIntN}, 8'h0f, "apic");
    u_pir_isa_host.wr(2'b11, 8'h80);
    rd(2'b01, 8'h80);
    for (i = 0; i < 16; i = i + 1) begin
      seed = xs(seed);
      u_pir_isa_host.wr({seed[0], 1'b0}, {4'h0, i[3:0]});
      srcN = ~(5'h01 << (seed[4:2] % 5));
      {cascIntBN, cascIntCN, cascIntDN} = {seed[6:5], 1'b0};
      repeat (3) @(posedge sys_clk) #1;
      expIrq = irqOf(i[3:0]);
      chk(isaIrqOe, expIrq | 8'h80, "irqOe");
      chk(isaIrqOut, expIrq | 8'h80, "irqOut");
      chk(8'(apicPciIntN), {5'h01, cascIntCN, cascIntBN, |expIrq}, "apic");
      rd({~seed[0], 1'b0}, {4'h0, i[3:0]});
    end
    for (k = 0; k < 2; k = k + 1) begin
      u_pir_isa_host.wr(2'b00, 8'h01);
      {isaRstN, pciRstN} = k ? 2'b10 : 2'b01;
      u_pir_isa_host.wr(2'b00, 8'h05);
      {isaRstN, pciRstN} = 2'b11;
      rd(2'b00, 8'h00);
      rd(2'b01, 8'h00);
    end
    for (k = 0; k < 4; k = k + 1) begin
      e = 7'({7'h50, 7'h13, 7'h4a, 7'h27} >> (7 * k));
      {smiEnable, nmiEnable, errReq, critErr, bridgeNmiReq} = e[6:2];
      @(posedge sys_clk) #1;
      {errReq, critErr, bridgeNmiReq} = 3'h0;
      repeat (3) @(posedge sys_clk) #1;
      chk(8'({cpuNmi, mgmt_interrupt_n}), 8'(e[1:0]), "nmiSmi");
      {smiClear, nmiClear} = 2'b11;
      @(posedge sys_clk) #1;
      {smiClear, nmiClear} = 2'b00;
      repeat (3) @(posedge sys_clk) #1;
      chk(8'({cpuNmi, mgmt_interrupt_n}), 8'h01, "nmiClr");
    end
    // Front panel press in the same cycle as a clear: the press must win
    {fpNmiN, nmiClear} = 2'b01;
    @(posedge sys_clk) #1;
    {fpNmiN, nmiClear} = 2'b10;
    repeat (2) @(posedge sys_clk) #1;
    chk(8'(cpuNmi), 8'h01, "fpNmi");
    // Mid-run reset with routing and NMI both active
    u_pir_isa_host.wr(2'b01, 8'h53);
    {cascIntBN, cascIntCN, cascIntDN} = 3'h7;
    rst_b = 1'b0;
    @(posedge sys_clk) #1;
    chk(isaIrqOe, 8'h00, "rstOe");
    chk({apicPciIntN, 1'b0, cpuNmi, mgmt_interrupt_n, dataOe}, 8'hf2, "rstOut");
    rst_b = 1'b1;
    rd(2'b01, 8'h00);
    rd(2'b00, 8'h00);
    test_done;
  end
endmodule
bind pir_rerouter pir_rerouter_chk u_pir_rerouter_chk (.*);
